// ### core/assc_core.sv
// sequencer, post-processor, dac accumulators and apb slave of the core
`timescale 1ns/1ps
module assc_core (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	// fabric side
	input wire logic fabricSequenceTrigger,
	input wire logic fabricDac0Data,
	input wire logic fabricDac0Clock,
	input wire logic fabricDac1Data,
	input wire logic fabricDac1Clock,
	input wire logic fabricDac2Data,
	input wire logic fabricDac2Clock,
	output logic [31:0] thresholdFlags,
	// converters
	output logic [2:0] adcStart,
	output logic [11:0] adcChannel,
	input wire logic [2:0] adcDone,
	input wire logic [35:0] adcResult,
	// analog config bus, dacs, dma, interrupt
	output assc_pkg::assc_acb_t acbOut,
	output logic [2:0] dacData,
	output logic [2:0] dacClock,
	output assc_pkg::assc_dma_t dmaOut,
	output logic seqIrq
);
	logic trigMeta, trigSync, runPrev, divClk, ppeEnable;
	logic [4:0] slotCtrl;
	logic [2:0] syncCtrl, running, waiting, sampleIrqEn, dacCarry;
	logic [5:0] irqStat, irqMask;
	logic [31:0] workA, workB, workC, flags, rdData;
	logic [15:0] workD, workE;
	logic [11:0] pickHeld;
	logic [23:0] dacIncr [3];
	logic [23:0] dacAcc [3];
	logic [15:0] seqMem [assc_pkg::SEQ_DEPTH];
	logic [15:0] ppeMem [assc_pkg::PPE_DEPTH];
	logic [5:0] pc [3];
	logic [3:0] loopCnt [3][2];
	logic [3:0] chanSel [3];
	logic [15:0] fifoMem [3][assc_pkg::FIFO_DEPTH];
	logic [2:0] fifoWr [3];
	logic [2:0] fifoRd [3];
	logic [1:0] rr, pcur;
	logic [4:0] ppc;
	logic [3:0] pchan;
	assc_pkg::assc_slot_t slot, next_slot;
	assc_pkg::assc_ppe_t pst;

	function automatic logic [1:0] nextConv(input logic [1:0] k);
		return (k == 2'h2) ? 2'h0 : k + 2'h1;
	endfunction : nextConv

	function automatic logic [5:0] seqEntry(input logic [1:0] k);
		return 6'(k) << assc_pkg::SEQ_ENTRY_SHIFT;
	endfunction : seqEntry

	function automatic logic [31:0] smul(input logic [15:0] a,
		input logic [15:0] b);
		return $signed({{16{a[15]}}, a}) * $signed({{16{b[15]}}, b});
	endfunction : smul

	// trigger is asynchronous to the engine clock
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			trigMeta <= 1'b0;
			trigSync <= 1'b0;
		end else begin
			trigMeta <= fabricSequenceTrigger;
			trigSync <= trigMeta;
		end
	end

	// slot counter
	wire slotRun = slotCtrl[assc_pkg::SC_EN] | trigSync;
	wire shared = (slot == assc_pkg::SLOT_SH);
	always_comb begin
		next_slot = assc_pkg::SLOT_SH; // idle: bus only
		if (slotRun) begin
			case (slot)
			assc_pkg::SLOT_C0: next_slot = assc_pkg::SLOT_C1;
			assc_pkg::SLOT_C1: next_slot = assc_pkg::SLOT_C2;
			assc_pkg::SLOT_C2: next_slot = assc_pkg::SLOT_SH;
			default: next_slot = assc_pkg::SLOT_C0;
			endcase
		end
	end

	// apb decode; transfers complete only inside the shared slot
	wire apbXfer = PSEL & PENABLE & PREADY;
	wire apbWr = apbXfer & PWRITE;
	wire hitSeq = PADDR[31:8] == assc_pkg::ADDR_SEQ_MEM[31:8];
	wire hitPpe = PADDR[31:7] == assc_pkg::ADDR_PPE_MEM[31:7];
	wire wrSlot = apbWr && PADDR == assc_pkg::ADDR_SLOT_CTRL;
	wire wrSync = apbWr && PADDR == assc_pkg::ADDR_SYNC_CTRL;
	wire wrPpeCtl = apbWr && PADDR == assc_pkg::ADDR_PPE_CTRL;
	wire wrIrqClr = apbWr && PADDR == assc_pkg::ADDR_IRQ_STAT;
	wire wrIrqMask = apbWr && PADDR == assc_pkg::ADDR_IRQ_MASK;
	wire [2:0] wrDac = {apbWr && PADDR == assc_pkg::ADDR_DAC2,
		apbWr && PADDR == assc_pkg::ADDR_DAC1,
		apbWr && PADDR == assc_pkg::ADDR_DAC0};

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			slot <= assc_pkg::SLOT_SH;
			PREADY <= 1'b1;
			PRDATA <= assc_pkg::RST_WORK;
		end else begin
			slot <= next_slot;
			PREADY <= next_slot == assc_pkg::SLOT_SH;
			PRDATA <= rdData;
		end
	end

	always_comb begin
		case (PADDR)
		assc_pkg::ADDR_WORK_A: rdData = workA;
		assc_pkg::ADDR_WORK_B: rdData = workB;
		assc_pkg::ADDR_WORK_C: rdData = workC;
		assc_pkg::ADDR_WORK_D: rdData = {16'h0000, workD};
		assc_pkg::ADDR_WORK_E: rdData = {16'h0000, workE};
		assc_pkg::ADDR_SLOT_CTRL: rdData = {27'h0, slotCtrl};
		assc_pkg::ADDR_SYNC_CTRL: rdData = {29'h0, syncCtrl};
		assc_pkg::ADDR_PPE_CTRL:
			rdData = {30'h0, pst == assc_pkg::PST_IDLE, ppeEnable};
		assc_pkg::ADDR_IRQ_STAT: rdData = {26'h0, irqStat};
		assc_pkg::ADDR_IRQ_MASK: rdData = {26'h0, irqMask};
		assc_pkg::ADDR_FLAGS: rdData = flags;
		assc_pkg::ADDR_DAC0: rdData = {8'h00, dacIncr[0]};
		assc_pkg::ADDR_DAC1: rdData = {8'h00, dacIncr[1]};
		assc_pkg::ADDR_DAC2: rdData = {8'h00, dacIncr[2]};
		assc_pkg::ADDR_PC0: rdData = {26'h0, pc[0]};
		assc_pkg::ADDR_PC1: rdData = {26'h0, pc[1]};
		assc_pkg::ADDR_PC2: rdData = {26'h0, pc[2]};
		default: rdData = 32'h0000_0000;
		endcase
	end

	// control registers written by the bus master
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			slotCtrl <= assc_pkg::RST_SLOT_CTRL;
			syncCtrl <= assc_pkg::RST_SYNC_CTRL;
			ppeEnable <= 1'b0;
			irqMask <= assc_pkg::RST_IRQ;
			for (int k = 0; k < 3; k++) dacIncr[k] <= assc_pkg::RST_DAC;
		end else begin
			if (wrSlot) slotCtrl <= PWDATA[4:0];
			if (wrSync) syncCtrl <= PWDATA[2:0];
			if (wrPpeCtl) ppeEnable <= PWDATA[0];
			if (wrIrqMask) irqMask <= PWDATA[5:0];
			for (int k = 0; k < 3; k++) begin
				if (wrDac[k]) dacIncr[k] <= PWDATA[23:0];
			end
		end
	end

	// program memories: bus writes them, engines read them
	always_ff @(posedge sys_clk) begin
		if (apbWr && hitSeq) seqMem[PADDR[7:2]] <= PWDATA[15:0];
		if (apbWr && hitPpe) ppeMem[PADDR[6:2]] <= PWDATA[15:0];
	end

	// sequencer: one instruction per converter slot
	wire [1:0] cur = (slot == assc_pkg::SLOT_C1) ? 2'h1 :
		(slot == assc_pkg::SLOT_C2) ? 2'h2 : 2'h0;
	wire [15:0] insn = seqMem[pc[cur]];
	wire [3:0] op = insn[15:12];
	wire exec = slotRun & ~shared & running[cur] & ~waiting[cur];
	wire launch = slotRun & ~runPrev;
	wire lvl = insn[8];
	wire [2:0] endEvt = 3'(exec && op == assc_pkg::SQ_END) << cur;
	wire [2:0] waitLeft = waiting & ~adcDone;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int k = 0; k < 3; k++) begin
				pc[k] <= 6'h00;
				loopCnt[k][0] <= 4'h0;
				loopCnt[k][1] <= 4'h0;
				chanSel[k] <= 4'h0;
			end
			running <= 3'h0;
			waiting <= 3'h0;
			sampleIrqEn <= 3'h0;
			adcStart <= 3'h0;
			acbOut <= '0;
			runPrev <= 1'b0;
		end else begin
			runPrev <= slotRun;
			adcStart <= 3'h0;
			acbOut.wr <= 1'b0;
			waiting <= waitLeft;
			if (launch) begin
				running <= 3'h7;
				for (int k = 0; k < 3; k++) pc[k] <= seqEntry(2'(k));
			end else if (exec) begin
				pc[cur] <= pc[cur] + 6'h01;
				case (op)
				assc_pkg::SQ_CFG:
					acbOut <= '{1'b1, insn[11:8], insn[7:0]};
				assc_pkg::SQ_START: begin
					adcStart[cur] <= 1'b1;
					chanSel[cur] <= insn[11:8];
					sampleIrqEn[cur] <= insn[7];
					waiting[cur] <= 1'b1;
				end
				assc_pkg::SQ_SYNC: begin
					adcStart <= syncCtrl;
					waiting <= waitLeft | syncCtrl;
					for (int k = 0; k < 3; k++) begin
						if (syncCtrl[k]) chanSel[k] <= insn[11:8];
						if (syncCtrl[k]) sampleIrqEn[k] <= insn[7];
					end
				end
				assc_pkg::SQ_LOOP: loopCnt[cur][lvl] <= insn[3:0];
				assc_pkg::SQ_NEXT: begin
					if (loopCnt[cur][lvl] != 4'h0) begin
						loopCnt[cur][lvl] <= loopCnt[cur][lvl] - 4'h1;
						pc[cur] <= insn[5:0];
					end
				end
				assc_pkg::SQ_JMP: pc[cur] <= insn[5:0];
				assc_pkg::SQ_END: begin
					if (insn[0]) pc[cur] <= seqEntry(cur);
					else running[cur] <= 1'b0;
				end
				default: ;
				endcase
			end
		end
	end

	always_comb begin
		for (int k = 0; k < 3; k++) adcChannel[k*4 +: 4] = chanSel[k];
	end

	// interrupts: set wins over a write-one clear
	wire [5:0] irqClr = wrIrqClr ? PWDATA[5:0] : 6'h00;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqStat <= assc_pkg::RST_IRQ;
			seqIrq <= 1'b0;
		end else begin
			irqStat <= (irqStat & ~irqClr) | {endEvt, adcDone & sampleIrqEn};
			seqIrq <= |(irqStat & irqMask);
		end
	end

	// raw result fifos, one per converter
	wire [2:0] fifoEmpty, fifoFull;
	for (genvar j = 0; j < 3; j++) begin : g_fifo
		assign fifoEmpty[j] = fifoWr[j] == fifoRd[j];
		assign fifoFull[j] = (fifoWr[j] ^ fifoRd[j]) == 3'h4;
	end
	wire [1:0] rr1 = nextConv(rr);
	wire [1:0] pick = ~fifoEmpty[rr] ? rr :
		~fifoEmpty[rr1] ? rr1 : nextConv(rr1);
	wire ppeTake = ppeEnable & (pst == assc_pkg::PST_IDLE) & ~&fifoEmpty;
	wire [15:0] pickData = fifoMem[pick][fifoRd[pick][1:0]];

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int k = 0; k < 3; k++) begin
				fifoWr[k] <= 3'h0;
				fifoRd[k] <= 3'h0;
			end
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (adcDone[k] && !fifoFull[k]) fifoWr[k] <= fifoWr[k] + 3'h1;
				if (ppeTake && pick == 2'(k)) fifoRd[k] <= fifoRd[k] + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int k = 0; k < 3; k++) begin
			if (adcDone[k] && !fifoFull[k])
				fifoMem[k][fifoWr[k][1:0]] <= {chanSel[k], adcResult[k*12 +: 12]};
		end
	end

	// post-processor; output needs a free shared slot
	wire [15:0] pinsn = ppeMem[ppc];
	wire [3:0] pop = pinsn[15:12];
	wire rawOut = |adcDone;
	wire outGo = slotRun & shared & ~PSEL & ~rawOut;
	wire pRun = pst == assc_pkg::PST_RUN;
	wire pStep = pRun & (pop != assc_pkg::PP_OUT | outGo);
	wire apbAlu = apbWr && PADDR[31:8] == assc_pkg::ADDR_WORK_A[31:8];
	wire [31:0] diff = workA - workB;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pst <= assc_pkg::PST_IDLE;
			rr <= 2'h0;
			pcur <= 2'h0;
			pchan <= 4'h0;
			ppc <= 5'h00;
			flags <= assc_pkg::RST_WORK;
		end else if (ppeTake) begin
			pst <= assc_pkg::PST_RUN;
			pcur <= pick;
			pchan <= pickData[15:12];
			ppc <= 5'(pick) << assc_pkg::PPE_ENTRY_SHIFT;
		end else if (pStep) begin
			ppc <= ppc + 5'h01;
			if (pop == assc_pkg::PP_THR)
				flags[pinsn[4:0]] <= workA[23:8] > workE;
			if (pop == assc_pkg::PP_END) begin
				pst <= assc_pkg::PST_IDLE;
				rr <= nextConv(pcur);
			end
		end
	end

	// work registers; the bus write wins a same-cycle clash
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			workA <= assc_pkg::RST_WORK;
			workB <= assc_pkg::RST_WORK;
			workC <= assc_pkg::RST_WORK;
			workD <= assc_pkg::RST_WORK[15:0];
			workE <= assc_pkg::RST_WORK[15:0];
		end else if (apbAlu) begin
			case (PADDR[7:0])
			assc_pkg::ADDR_WORK_A[7:0]: workA <= PWDATA;
			assc_pkg::ADDR_WORK_B[7:0]: workB <= PWDATA;
			assc_pkg::ADDR_WORK_C[7:0]: workC <= PWDATA;
			assc_pkg::ADDR_WORK_D[7:0]: workD <= PWDATA[15:0];
			assc_pkg::ADDR_WORK_E[7:0]: workE <= PWDATA[15:0];
			default: ;
			endcase
		end else if (pStep) begin
			case (pop)
			assc_pkg::PP_LDA: workA <= {12'h000, pickHeld, 8'h00};
			assc_pkg::PP_LIN: workA <= smul(workD, workA[23:8]) + workC;
			assc_pkg::PP_LPF: workB <= workB + smul(workE, diff[23:8]);
			default: ;
			endcase
		end
	end

	// sample taken from the fifo is held for the load instruction
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) pickHeld <= 12'h000;
		else if (ppeTake) pickHeld <= pickData[11:0];
	end

	// dma word: raw results outrank processed ones
	wire [1:0] dIdx = adcDone[0] ? 2'h0 : adcDone[1] ? 2'h1 : 2'h2;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) dmaOut <= '0;
		else if (rawOut) dmaOut <= '{1'b1, {2'h0, dIdx, chanSel[dIdx], 4'h0,
			adcResult[dIdx*12 +: 12], 8'h00}};
		else if (pRun && pop == assc_pkg::PP_OUT && outGo)
			dmaOut <= '{1'b1, {2'h0, pcur, pchan, workB[31:8]}};
		else dmaOut.valid <= 1'b0;
	end

	// threshold flags, ten replaceable by engine state
	wire [9:0] dbg = {slot, waiting, running};
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) thresholdFlags <= assc_pkg::RST_WORK;
		else if (slotCtrl[assc_pkg::SC_DBG])
			thresholdFlags <= {flags[31:10], dbg};
		else thresholdFlags <= flags;
	end

	// dac phase accumulators; carry is the bit stream
	wire [2:0] fabSel = slotCtrl[assc_pkg::SC_FAB +: 3];
	wire [2:0] fabD = {fabricDac2Data, fabricDac1Data, fabricDac0Data};
	wire [2:0] fabC = {fabricDac2Clock, fabricDac1Clock, fabricDac0Clock};
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int k = 0; k < 3; k++) dacAcc[k] <= assc_pkg::RST_DAC;
			dacCarry <= 3'h0;
			divClk <= 1'b0;
			dacData <= 3'h0;
			dacClock <= 3'h0;
		end else begin
			divClk <= ~divClk;
			for (int k = 0; k < 3; k++)
				{dacCarry[k], dacAcc[k]} <= {1'b0, dacAcc[k]} + {1'b0, dacIncr[k]};
			dacData <= (fabSel & fabD) | (~fabSel & dacCarry);
			dacClock <= (fabSel & fabC) | (~fabSel & {3{divClk}});
		end
	end
endmodule : assc_core

// ### core/assc_pkg.sv
// constants, opcodes and carrier types of the analog sample sequencer core
package assc_pkg;
	typedef enum logic [3:0] {
		SLOT_C0 = 4'h1,
		SLOT_C1 = 4'h2,
		SLOT_C2 = 4'h4,
		SLOT_SH = 4'h8
	} assc_slot_t;
	typedef enum logic [1:0] {PST_IDLE = 2'h1, PST_RUN = 2'h2} assc_ppe_t;
	typedef struct packed {
		logic wr;
		logic [3:0] addr;
		logic [7:0] data;
	} assc_acb_t;
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} assc_dma_t;
	localparam logic [31:0] ADDR_WORK_A = 32'h0400_2120;
	localparam logic [31:0] ADDR_WORK_B = 32'h0400_2128;
	localparam logic [31:0] ADDR_WORK_C = 32'h0400_2130;
	localparam logic [31:0] ADDR_WORK_D = 32'h0400_2138;
	localparam logic [31:0] ADDR_WORK_E = 32'h0400_2140;
	localparam logic [31:0] ADDR_SLOT_CTRL = 32'h0400_2200;
	localparam logic [31:0] ADDR_SYNC_CTRL = 32'h0400_2204;
	localparam logic [31:0] ADDR_PPE_CTRL = 32'h0400_2208;
	localparam logic [31:0] ADDR_IRQ_STAT = 32'h0400_220C;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'h0400_2210;
	localparam logic [31:0] ADDR_FLAGS = 32'h0400_2214;
	localparam logic [31:0] ADDR_DAC0 = 32'h0400_2218;
	localparam logic [31:0] ADDR_DAC1 = 32'h0400_221C;
	localparam logic [31:0] ADDR_DAC2 = 32'h0400_2220;
	localparam logic [31:0] ADDR_PC0 = 32'h0400_2224;
	localparam logic [31:0] ADDR_PC1 = 32'h0400_2228;
	localparam logic [31:0] ADDR_PC2 = 32'h0400_222C;
	localparam logic [31:0] ADDR_SEQ_MEM = 32'h0400_1000;
	localparam logic [31:0] ADDR_PPE_MEM = 32'h0400_1800;
	localparam int SEQ_DEPTH = 64;
	localparam int PPE_DEPTH = 32;
	localparam int FIFO_DEPTH = 4;
	localparam int SEQ_ENTRY_SHIFT = 4;
	localparam int PPE_ENTRY_SHIFT = 3;
	localparam int SC_EN = 0;
	localparam int SC_FAB = 1;
	localparam int SC_DBG = 4;
	localparam logic [31:0] RST_WORK = 32'h0000_0000;
	localparam logic [4:0] RST_SLOT_CTRL = 5'h00;
	localparam logic [2:0] RST_SYNC_CTRL = 3'h0;
	localparam logic [5:0] RST_IRQ = 6'h00;
	localparam logic [23:0] RST_DAC = 24'h00_0000;
	localparam logic [3:0] SQ_CFG = 4'h1;
	localparam logic [3:0] SQ_START = 4'h2;
	localparam logic [3:0] SQ_SYNC = 4'h3;
	localparam logic [3:0] SQ_LOOP = 4'h4;
	localparam logic [3:0] SQ_NEXT = 4'h5;
	localparam logic [3:0] SQ_JMP = 4'h6;
	localparam logic [3:0] SQ_END = 4'h7;
	localparam logic [3:0] PP_LDA = 4'h1;
	localparam logic [3:0] PP_LIN = 4'h2;
	localparam logic [3:0] PP_LPF = 4'h3;
	localparam logic [3:0] PP_THR = 4'h4;
	localparam logic [3:0] PP_OUT = 4'h5;
	localparam logic [3:0] PP_END = 4'h6;
endpackage : assc_pkg

// ### tb/assc_core_sva.sv
// port-level assertions for the analog sample sequencer core
`timescale 1ns/1ps
module assc_core_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PREADY,
	// fabric, converters, dacs, dma
	input wire logic fabricSequenceTrigger,
	input wire logic fabricDac0Data,
	input wire logic fabricDac0Clock,
	input wire logic [2:0] adcStart,
	input wire logic [2:0] adcDone,
	input wire logic [35:0] adcResult,
	input wire logic [2:0] dacData,
	input wire logic [2:0] dacClock,
	input wire assc_pkg::assc_dma_t dmaOut
);
	logic [4:0] ctrl;
	logic [3:0] onCnt;
	logic [3:0] offCnt;
	logic [3:0] age;
	wire ctrlWr = PSEL && PENABLE && PREADY && PWRITE
		&& PADDR == assc_pkg::ADDR_SLOT_CTRL;
	wire runReq = ctrl[assc_pkg::SC_EN] || fabricSequenceTrigger;
	// counters saturate so long runs never wrap back into the guard window
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= 5'h00;
			onCnt <= 4'h0;
			offCnt <= 4'h0;
			age <= 4'h0;
		end else begin
			if (ctrlWr) ctrl <= PWDATA[4:0];
			onCnt <= !runReq ? 4'h0 : onCnt + {3'h0, onCnt != 4'hF};
			offCnt <= runReq ? 4'h0 : offCnt + {3'h0, offCnt != 4'hF};
			age <= ctrlWr ? 4'h0 : age + {3'h0, age != 4'hF};
		end
	end
	chk_bus_ready: assert property (
		@(posedge sys_clk) disable iff (!arst_n) (offCnt >= 4'h6) |-> PREADY)
		else $error("ready dropped in bus-only mode");
	// enable loss aborts the window: slot timing restarts from the shared slot
	chk_slot_cadence: assert property (
		@(posedge sys_clk) disable iff (!arst_n || !runReq)
		(onCnt >= 4'h8 && PREADY) |=> !PREADY [*3] ##1 PREADY)
		else $error("shared slot not one in four");
	chk_ready_bound: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(onCnt >= 4'h8) |-> ##[0:3] PREADY)
		else $error("shared slot missing within four cycles");
	chk_start_spacing: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		adcStart[0] |=> !adcStart[0] [*3])
		else $error("converter 0 started outside its slot");
	chk_idle_start: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(offCnt >= 4'h6) |-> adcStart == 3'h0)
		else $error("conversion started with slots disabled");
	chk_raw_dma: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		adcDone[0] |=> dmaOut.valid && dmaOut.data[29:28] == 2'h0
		&& dmaOut.data[19:8] == $past(adcResult[11:0]))
		else $error("raw result not forwarded");
	chk_dac_fabric: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(ctrl[1] && age >= 4'h3) |-> dacData[0] == $past(fabricDac0Data)
		&& dacClock[0] == $past(fabricDac0Clock))
		else $error("dac 0 not following fabric feed");
	chk_dac_toggle: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(!ctrl[3] && age >= 4'h3) |-> dacClock[2] != $past(dacClock[2]))
		else $error("dac 2 accumulator clock stalled");
endmodule : assc_core_sva

bind assc_core assc_core_sva assc_core_sva_i (
	.sys_clk(sys_clk), .arst_n(arst_n), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
	.fabricSequenceTrigger(fabricSequenceTrigger),
	.fabricDac0Data(fabricDac0Data), .fabricDac0Clock(fabricDac0Clock),
	.adcStart(adcStart), .adcDone(adcDone), .adcResult(adcResult),
	.dacData(dacData), .dacClock(dacClock), .dmaOut(dmaOut));

// ### tb/assc_fabric_model.sv
// converters and fabric dac feed facing the core
`timescale 1ns/1ps
module assc_fabric_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// converters
	input wire logic [2:0] adcStart,
	output logic [2:0] adcDone,
	output logic [35:0] adcResult,
	// fabric dac feed
	output logic [2:0] fabData,
	output logic [2:0] fabClk
);
	localparam logic [35:0] RES = 36'h5A2_5A1_5A0;
	logic [8:0] pipe;
	logic [3:0] cnt;
	assign adcDone = pipe[8:6];
	// result only valid with done, inverted otherwise so stale reads show
	assign adcResult = (adcDone != 3'h0) ? RES : ~RES;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pipe <= 9'h000;
			cnt <= 4'h0;
		end else begin
			pipe <= {pipe[5:0], adcStart};
			cnt <= cnt + 4'h1;
		end
	end
	assign fabClk = {3{cnt[0]}};
	assign fabData = cnt[3:1] ^ {cnt[2], cnt[0], cnt[3]};
endmodule : assc_fabric_model

// ### tb/assc_core_bench.sv
// self-checking bench of the analog sample sequencer core
`timescale 1ns/1ps
module assc_core_bench;
	localparam logic [31:0] W_ADDR [0:4] = '{assc_pkg::ADDR_WORK_A,
		assc_pkg::ADDR_WORK_B, assc_pkg::ADDR_WORK_C,
		assc_pkg::ADDR_WORK_D, assc_pkg::ADDR_WORK_E};
	localparam logic [31:0] W_DATA [0:4] = '{32'hA5A5_0F0F,
		32'h1234_5678, 32'h8000_0001, 32'hFFFF_0034, 32'hABCD_0012};
	localparam logic [31:0] W_EXP [0:4] = '{32'hA5A5_0F0F,
		32'h1234_5678, 32'h8000_0001, 32'h0000_0034, 32'h0000_0012};
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [31:0] PADDR = 32'h0000_0000;
	logic [31:0] PWDATA = 32'h0000_0000;
	logic trig = 1'b0;
	logic [31:0] PRDATA;
	logic [31:0] thresholdFlags;
	logic PREADY;
	logic seqIrq;
	logic [2:0] adcStart;
	logic [2:0] adcDone;
	logic [2:0] dacData;
	logic [2:0] dacClock;
	logic [2:0] fabData;
	logic [2:0] fabClk;
	logic [11:0] adcChannel;
	logic [35:0] adcResult;
	assc_pkg::assc_acb_t acbOut;
	assc_pkg::assc_acb_t acbLast = '0;
	assc_pkg::assc_dma_t dmaOut;
	logic [31:0] dmaData = 32'h0000_0000;
	logic dmaSeen = 1'b0;
	logic [31:0] procData = 32'h0000_0000;
	logic procSeen = 1'b0;
	logic syncSeen = 1'b0;
	logic [31:0] rdData;
	logic [31:0] waitCnt;
	logic [31:0] lows;
	int error_cnt = 0;
	int check_count = 0;
	int cycles = 0;

	assc_core assc_core_i (.sys_clk(sys_clk), .arst_n(arst_n),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.fabricSequenceTrigger(trig),
		.fabricDac0Data(fabData[0]), .fabricDac0Clock(fabClk[0]),
		.fabricDac1Data(fabData[1]), .fabricDac1Clock(fabClk[1]),
		.fabricDac2Data(fabData[2]), .fabricDac2Clock(fabClk[2]),
		.thresholdFlags(thresholdFlags), .adcStart(adcStart),
		.adcChannel(adcChannel), .adcDone(adcDone), .adcResult(adcResult),
		.acbOut(acbOut), .dacData(dacData), .dacClock(dacClock),
		.dmaOut(dmaOut), .seqIrq(seqIrq));
	assc_fabric_model assc_fabric_model_i (.sys_clk(sys_clk),
		.arst_n(arst_n), .adcStart(adcStart), .adcDone(adcDone),
		.adcResult(adcResult), .fabData(fabData), .fabClk(fabClk));

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	// outputs are registered, so look at them mid-cycle
	always @(negedge sys_clk) begin
		if (acbOut.wr === 1'b1) acbLast <= acbOut;
		if (adcStart === 3'h7) syncSeen <= 1'b1;
		if (dmaOut.valid === 1'b1 && !dmaSeen) begin
			dmaSeen <= 1'b1;
			dmaData <= dmaOut.data;
		end
		// raw words always carry converter 0 here, so 1 marks processed
		if (dmaOut.valid === 1'b1 && dmaOut.data[29:28] === 2'h1
			&& !procSeen) begin
			procSeen <= 1'b1;
			procData <= dmaOut.data;
		end
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one apb transfer; a stalled shared slot gives up after 20 waits
	task automatic apb(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		#2;
		PSEL = 1'b1;
		PWRITE = wr;
		PADDR = a;
		PWDATA = d;
		waitCnt = 32'h0;
		@(posedge sys_clk);
		#2;
		PENABLE = 1'b1;
		while (PREADY !== 1'b1 && waitCnt < 32'h14) begin
			@(posedge sys_clk);
			#2;
			waitCnt++;
		end
		if (waitCnt >= 32'h14) begin
			error_cnt++;
			$display("[FAIL] apb ready expected 1 seen %b", PREADY);
		end
		rdData = PRDATA;
		@(posedge sys_clk);
		#2;
		PSEL = 1'b0;
		PENABLE = 1'b0;
	endtask : apb

	task automatic rd_chk(input string what, input logic [31:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, exp, rdData);
	endtask : rd_chk

	task automatic count_lows();
		lows = 32'h0;
		repeat (8) begin
			@(posedge sys_clk);
			#2;
			if (PREADY === 1'b0) lows++;
		end
	endtask : count_lows

	initial begin
		repeat (10) @(posedge sys_clk);
		#2;
		arst_n = 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd_chk("work reset", W_ADDR[i], 32'h0);
			check("bus-only waits", 32'h0, waitCnt);
		end
		for (int i = 0; i < 5; i++) apb(1'b1, W_ADDR[i], W_DATA[i]);
		for (int i = 0; i < 5; i++) rd_chk("work reg", W_ADDR[i], W_EXP[i]);
		rd_chk("unmapped", 32'h0400_2144, 32'h0);
		// converter 0: config write, sync start of all three, stop
		apb(1'b1, assc_pkg::ADDR_SEQ_MEM, 32'h135A);
		apb(1'b1, assc_pkg::ADDR_SEQ_MEM + 32'h4, 32'h3500);
		apb(1'b1, assc_pkg::ADDR_SEQ_MEM + 32'h8, 32'h7000);
		apb(1'b1, assc_pkg::ADDR_SEQ_MEM + 32'h40, 32'h7000);
		apb(1'b1, assc_pkg::ADDR_SEQ_MEM + 32'h80, 32'h7000);
		// fifo 0: load, y = mx + b, flag 3; fifo 1: filter, out; fifo 2 ends
		apb(1'b1, assc_pkg::ADDR_PPE_MEM, 32'h1000);
		apb(1'b1, assc_pkg::ADDR_PPE_MEM + 32'h4, 32'h2000);
		apb(1'b1, assc_pkg::ADDR_PPE_MEM + 32'h8, 32'h4003);
		apb(1'b1, assc_pkg::ADDR_PPE_MEM + 32'hC, 32'h6000);
		apb(1'b1, assc_pkg::ADDR_PPE_MEM + 32'h20, 32'h3000);
		apb(1'b1, assc_pkg::ADDR_PPE_MEM + 32'h24, 32'h5000);
		apb(1'b1, assc_pkg::ADDR_PPE_MEM + 32'h28, 32'h6000);
		apb(1'b1, assc_pkg::ADDR_PPE_MEM + 32'h40, 32'h6000);
		apb(1'b1, assc_pkg::ADDR_SYNC_CTRL, 32'h7);
		apb(1'b1, assc_pkg::ADDR_PPE_CTRL, 32'h1);
		apb(1'b1, assc_pkg::ADDR_SLOT_CTRL, 32'h1);
		for (int i = 0; i < 400; i++) begin
			if (dmaSeen && thresholdFlags[3] === 1'b1) break;
			@(posedge sys_clk);
		end
		check("config bus", 32'h35A,
			{20'h0, acbLast.addr, acbLast.data});
		check("sync start", 32'h1, {31'h0, syncSeen});
		check("channels", 32'h555, {20'h0, adcChannel});
		check("raw dma", 32'h0505_A000, dmaData);
		check("flag 3", 32'h1, {31'h0, thresholdFlags[3]});
		count_lows();
		check("enabled ready lows", 32'h6, lows);
		rd_chk("work d", assc_pkg::ADDR_WORK_D, 32'h0000_0034);
		check("enabled waits", 32'h1, {31'h0, waitCnt <= 32'h3});
		rd_chk("lin a", assc_pkg::ADDR_WORK_A, 32'h8001_2481);
		rd_chk("lpf b", assc_pkg::ADDR_WORK_B, 32'h1230_BCF4);
		check("processed dma", 32'h1512_30BC, procData);
		rd_chk("irq status", assc_pkg::ADDR_IRQ_STAT, 32'h38);
		check("irq masked", 32'h0, {31'h0, seqIrq});
		apb(1'b1, assc_pkg::ADDR_IRQ_MASK, 32'h8);
		repeat (2) @(posedge sys_clk);
		#2;
		check("irq raised", 32'h1, {31'h0, seqIrq});
		apb(1'b1, assc_pkg::ADDR_IRQ_STAT, 32'h38);
		rd_chk("irq cleared", assc_pkg::ADDR_IRQ_STAT, 32'h0);
		apb(1'b1, assc_pkg::ADDR_SLOT_CTRL, 32'h0);
		repeat (8) @(posedge sys_clk);
		rd_chk("work e", assc_pkg::ADDR_WORK_E, 32'h0000_0012);
		check("disabled waits", 32'h0, waitCnt);
		trig = 1'b1;
		repeat (8) @(posedge sys_clk);
		count_lows();
		check("trigger ready lows", 32'h6, lows);
		trig = 1'b0;
		repeat (8) @(posedge sys_clk);
		count_lows();
		check("trigger off lows", 32'h0, lows);
		apb(1'b1, assc_pkg::ADDR_SLOT_CTRL, 32'h1E);
		repeat (20) @(posedge sys_clk);
		#2;
		check("debug slot", 32'h8, {28'h0, thresholdFlags[9:6]});
		complete_run();
	end
endmodule : assc_core_bench
